// [shared/tsc_params.svh]
// constants for the tear sync and scan order control block
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH
`define TSC_CMD_PARTIAL_ON   8'h12
`define TSC_CMD_NORMAL_ON    8'h13
`define TSC_CMD_SOFT_RESET   8'h01
`define TSC_CMD_TEAR_OFF     8'h34
`define TSC_CMD_TEAR_ON      8'h35
`define TSC_CMD_SCAN_CTRL    8'h36
`define TSC_CMD_SCROLL_START 8'h37
`define TSC_SCAN_RESET       8'h00
`define TSC_SCAN_USED_MASK   8'hFC
`define TSC_BIT_ROW_ORDER    7
`define TSC_BIT_COL_ORDER    6
`define TSC_BIT_ROW_COL_SWAP 5
`define TSC_BIT_VREFRESH_DIR 4
`define TSC_BIT_COLOR_ORDER  3
`define TSC_BIT_HREFRESH_DIR 2
`define TSC_BIT_TEAR_MODE    0
`endif

// [shared/tsc_pkg.sv]
// types for the tear sync and scan order control block
package tsc_pkg;
    typedef enum logic [2:0] {
        TSC_IDLE      = 3'b001,
        TSC_TEAR_PARM = 3'b010,
        TSC_SCAN_PARM = 3'b100
    } tsc_state_t;
endpackage

// [rtl/tsc_sync2.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tsc_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_r  <= INIT;
            syncOut <= INIT;
        end else begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule

// [rtl/tsc_edge_rise.sv]
// rising edge detector on a synchronised level
`timescale 1ns/1ps
module tsc_edge_rise (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic level,
    output logic      risePulse
);
    logic prev_r;

    // reset value high so a strobe idling high gives no false edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= level;
        end
    end
    assign risePulse = level & ~prev_r;
endmodule

// [rtl/tear_sync_and_scan_order_control.sv]
// command interpreter for tear sync output and memory scan control
`timescale 1ns/1ps
`include "tsc_params.svh"
module tear_sync_and_scan_order_control (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       cmdDataSelect,
    input  wire logic       readStrobe_n,
    input  wire logic       writeStrobe_n,
    input  wire logic [7:0] dataBus,
    input  wire logic       sleepIn,
    input  wire logic       vBlank,
    input  wire logic       hBlank,
    output logic            tearSyncOutput,
    output logic            tearSyncEnabled,
    output logic            tearLineMode,
    output logic [7:0]      memoryScanControl,
    output logic            rowOrderBit,
    output logic            columnOrderBit,
    output logic            rowColumnSwapBit,
    output logic            verticalRefreshDirBit,
    output logic            colorFilterOrderBit,
    output logic            horizontalRefreshDirBit,
    output logic            topAreaFromBottom,
    output logic            scrollModeActive,
    output logic            softResetSeen
);
    // all block state in one record
    typedef struct packed {
        tsc_pkg::tsc_state_t state;
        logic                tear_sync_on_cmd;
        logic                teMode;
        logic [7:0]          scan;
        logic                scroll;
        logic                teOut;
        logic                swReset;
    } tsc_regs_t;

    tsc_regs_t regs_r;
    tsc_regs_t regs_nxt;

    logic [2:0]  ctlSync;
    logic [2:0]  lvlSync;
    logic        wrRise;
    logic        isCmd;
    logic        rdHigh;
    logic [7:0]  busByte;
    logic        vBlankS;
    logic        hBlankS;
    logic        sleepS;

    // select and strobes; strobe flops start high so no false edge follows reset
    tsc_sync2 #(
        .WIDTH (3),
        .INIT  (3'h3)
    ) u_syncCtl (
        .core_clk (core_clk),
        .reset    (reset),
        .asyncIn  ({cmdDataSelect, readStrobe_n, writeStrobe_n}),
        .syncOut  (ctlSync)
    );

    // power state and blanking levels
    tsc_sync2 #(
        .WIDTH (3),
        .INIT  (3'h0)
    ) u_syncLvl (
        .core_clk (core_clk),
        .reset    (reset),
        .asyncIn  ({sleepIn, vBlank, hBlank}),
        .syncOut  (lvlSync)
    );

    // data byte; same depth as the strobe so byte and edge line up
    tsc_sync2 #(
        .WIDTH (8),
        .INIT  (8'h00)
    ) u_syncData (
        .core_clk (core_clk),
        .reset    (reset),
        .asyncIn  (dataBus),
        .syncOut  (busByte)
    );

    // unpack synchronised pins; host holds data well past the strobe edge
    assign isCmd   = ~ctlSync[2];
    assign rdHigh  = ctlSync[1];
    assign sleepS  = lvlSync[2];
    assign vBlankS = lvlSync[1];
    assign hBlankS = lvlSync[0];

    // byte latched on rising write strobe with read high
    tsc_edge_rise u_wr (
        .core_clk  (core_clk),
        .reset     (reset),
        .level     (ctlSync[0]),
        .risePulse (wrRise)
    );

    // command decode shared by the state machine
    function automatic logic isScrollExit(input logic [7:0] code);
        isScrollExit = (code == `TSC_CMD_NORMAL_ON) || (code == `TSC_CMD_PARTIAL_ON);
    endfunction

    // next-state logic; no power-state gating of commands on purpose, sleep gates only the tear output
    always_comb begin
        logic strobe;
        strobe   = 1'b0;
        regs_nxt = regs_r;
        regs_nxt.swReset = 1'b0;
        strobe = wrRise & rdHigh;
        if (strobe && isCmd) begin
            regs_nxt.state = tsc_pkg::TSC_IDLE;
            case (busByte)
                `TSC_CMD_TEAR_OFF: begin
                    regs_nxt.tear_sync_on_cmd = 1'b0;
                end
                `TSC_CMD_TEAR_ON: begin
                    regs_nxt.tear_sync_on_cmd  = 1'b1;
                    regs_nxt.state = tsc_pkg::TSC_TEAR_PARM;
                end
                `TSC_CMD_SCAN_CTRL: begin
                    regs_nxt.state = tsc_pkg::TSC_SCAN_PARM;
                end
                `TSC_CMD_SCROLL_START: begin
                    regs_nxt.scroll = 1'b1;
                end
                `TSC_CMD_SOFT_RESET: begin
                    regs_nxt.tear_sync_on_cmd    = 1'b0;
                    regs_nxt.teMode  = 1'b0;
                    regs_nxt.scan    = `TSC_SCAN_RESET;
                    regs_nxt.scroll  = 1'b0;
                    regs_nxt.swReset = 1'b1;
                end
                default: begin
                    if (isScrollExit(busByte)) begin
                        regs_nxt.scroll = 1'b0;
                    end
                end
            endcase
        end else if (strobe) begin
            case (regs_r.state)
                tsc_pkg::TSC_TEAR_PARM: begin
                    regs_nxt.teMode = busByte[`TSC_BIT_TEAR_MODE];
                    regs_nxt.state  = tsc_pkg::TSC_IDLE;
                end
                tsc_pkg::TSC_SCAN_PARM: begin
                    // only scan byte and state change here
                    regs_nxt.scan  = busByte & `TSC_SCAN_USED_MASK;
                    regs_nxt.state = tsc_pkg::TSC_IDLE;
                end
                tsc_pkg::TSC_IDLE: begin
                    regs_nxt.state = tsc_pkg::TSC_IDLE;
                end
                default: begin
                    regs_nxt.state = tsc_pkg::TSC_IDLE;
                end
            endcase
        end
        // tear output: blanking is high; scan bits never enter here
        if (!regs_r.tear_sync_on_cmd) begin
            regs_nxt.teOut = 1'b0;
        end else if (sleepS) begin
            regs_nxt.teOut = 1'b0;
        end else if (regs_r.teMode) begin
            regs_nxt.teOut = vBlankS | hBlankS;
        end else begin
            regs_nxt.teOut = vBlankS;
        end
    end

    // single state register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            regs_r <= '{state: tsc_pkg::TSC_IDLE, tear_sync_on_cmd: 1'b0, teMode: 1'b0,
                        scan: `TSC_SCAN_RESET, scroll: 1'b0, teOut: 1'b0, swReset: 1'b0};
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // outputs straight from the state flops
    assign tearSyncOutput          = regs_r.teOut;
    assign tearSyncEnabled         = regs_r.tear_sync_on_cmd;
    assign tearLineMode            = regs_r.teMode;
    assign memoryScanControl       = regs_r.scan;
    assign rowOrderBit             = regs_r.scan[`TSC_BIT_ROW_ORDER];
    assign columnOrderBit          = regs_r.scan[`TSC_BIT_COL_ORDER];
    assign rowColumnSwapBit        = regs_r.scan[`TSC_BIT_ROW_COL_SWAP];
    assign verticalRefreshDirBit   = regs_r.scan[`TSC_BIT_VREFRESH_DIR];
    assign colorFilterOrderBit     = regs_r.scan[`TSC_BIT_COLOR_ORDER];
    assign horizontalRefreshDirBit = regs_r.scan[`TSC_BIT_HREFRESH_DIR];
    assign topAreaFromBottom       = regs_r.scan[`TSC_BIT_VREFRESH_DIR];
    assign scrollModeActive        = regs_r.scroll;
    assign softResetSeen           = regs_r.swReset;
endmodule

// [bench/tsc_host_model.sv]
// host model driving the command and parameter bus
`timescale 1ns/1ps
module tsc_host_model (
    input  wire logic  core_clk,
    output logic       cmdDataSelect,
    output logic       readStrobe_n,
    output logic       writeStrobe_n,
    output logic [7:0] dataBus
);
    initial begin
        cmdDataSelect = 1'b0;
        readStrobe_n  = 1'b1;
        writeStrobe_n = 1'b1;
        dataBus       = 8'h00;
    end
    // one byte, taken at the strobe rise; gap stretches the low phase
    task automatic sendByte(input logic isParam, input logic [7:0] value, input int gap);
        @(negedge core_clk);
        cmdDataSelect = isParam;
        dataBus       = value;
        writeStrobe_n = 1'b0;
        repeat (4 + gap) @(negedge core_clk);
        writeStrobe_n = 1'b1;
        repeat (5) @(negedge core_clk);
        dataBus = ~value; // a released bus keeps no stale byte
    endtask
endmodule

// [bench/tsc_asserts.sv]
// checker for the tear sync and scan order outputs
`timescale 1ns/1ps
module tsc_asserts (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       sleepIn,
    input wire logic       vBlank,
    input wire logic       hBlank,
    input wire logic       tearSyncOutput,
    input wire logic       tearSyncEnabled,
    input wire logic       tearLineMode,
    input wire logic       scrollModeActive,
    input wire logic       softResetSeen,
    input wire logic       topAreaFromBottom,
    input wire logic       rowOrderBit,
    input wire logic       columnOrderBit,
    input wire logic       rowColumnSwapBit,
    input wire logic       verticalRefreshDirBit,
    input wire logic       colorFilterOrderBit,
    input wire logic       horizontalRefreshDirBit,
    input wire logic [7:0] memoryScanControl
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // reset values and field decode
    rst_clear_a: assert property ($fell(reset) |-> !tearSyncEnabled && memoryScanControl == 8'h00)
        else $error("reset state");
    soft_rst_a: assert property (softResetSeen |-> ##[0:1] (!tearSyncEnabled && memoryScanControl == 8'h00))
        else $error("soft reset state");
    field_map_a:
        assert property ({rowOrderBit, columnOrderBit, rowColumnSwapBit, verticalRefreshDirBit,
            colorFilterOrderBit, horizontalRefreshDirBit, 2'b00} == memoryScanControl) else $error("scan fields");
    top_area_a: assert property (topAreaFromBottom == memoryScanControl[4])
        else $error("top area origin");
    // tear output; four or five cycles cover the sync and register latency
    off_low_a: assert property ((!tearSyncEnabled)[*4] |-> !tearSyncOutput)
        else $error("tear driven while off");
    sleep_low_a: assert property ((sleepIn && tearSyncEnabled)[*5] |-> !tearSyncOutput)
        else $error("tear not low in sleep");
    vblank_only_a: assert property ((tearSyncEnabled && !tearLineMode && !sleepIn && $stable(vBlank))[*5]
        |-> tearSyncOutput == vBlank) else $error("mode 0 output");
    vh_blank_a: assert property ((tearSyncEnabled && tearLineMode && !sleepIn && $stable({vBlank, hBlank}))[*5]
        |-> tearSyncOutput == (vBlank | hBlank)) else $error("mode 1 output");
    scan_iso_a: assert property ($changed(memoryScanControl) && memoryScanControl != 8'h00 |->
        $stable(tearSyncEnabled) && $stable(tearLineMode) && $stable(scrollModeActive)) else $error("side effect");
    c_mode1: cover property (tearLineMode && tearSyncOutput);
    c_scroll: cover property ($fell(scrollModeActive));
    c_sleep: cover property (sleepIn && tearSyncEnabled);
    c_soft_rst: cover property (softResetSeen);
endmodule
bind tear_sync_and_scan_order_control tsc_asserts u_chk (.*);

// [bench/testbench.sv]
// self-checking bench for tear sync and scan order control
`timescale 1ns/1ps
module testbench;
    logic       core_clk = 1'b0, reset = 1'b1, sleepIn = 1'b0, vBlank = 1'b0, hBlank = 1'b0;
    logic       cmdDataSelect, readStrobe_n, writeStrobe_n, tearSyncOutput, tearSyncEnabled, tearLineMode;
    logic       rowOrderBit, columnOrderBit, rowColumnSwapBit, verticalRefreshDirBit, colorFilterOrderBit;
    logic       horizontalRefreshDirBit, topAreaFromBottom, scrollModeActive, softResetSeen, tearOn, mode;
    logic [7:0] dataBus, memoryScanControl, scan, b, fields;
    int         error_cnt = 0, comparisons = 0, cycles = 0;
    always #5 core_clk = ~core_clk;
    tear_sync_and_scan_order_control u_dut (.*);
    tsc_host_model u_host (.*);
    // expected tear level from bench-held state only
    function automatic logic expTear(input logic en, m, s, v, h);
        return en & !s & (v | (m & h));
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // random gap mixes prompt and slow hosts
    task automatic cmd(input logic [7:0] c);
        u_host.sendByte(1'b0, c, $urandom_range(0, 3));
    endtask
    task automatic prm(input logic [7:0] p);
        u_host.sendByte(1'b1, p, $urandom_range(0, 3));
    endtask
    task automatic tearChk(input logic s, v, h);
        sleepIn = s;
        vBlank = v;
        hBlank = h;
        repeat (6) @(negedge core_clk);
        chk("tearSyncOutput", {7'd0, expTear(tearOn, mode, s, v, h)}, {7'd0, tearSyncOutput});
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard, far above the fewer than a thousand cycles used
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        void'($urandom(8446));
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        chk("memoryScanControl", 8'h00, memoryScanControl);
        cmd(8'h34);
        prm(8'hFF); // stray parameter must be dropped
        chk("tearSyncEnabled", 8'h00, {7'd0, tearSyncEnabled});
        chk("memoryScanControl", 8'h00, memoryScanControl);
        tearOn = 1'b1;
        for (int i = 0; i < 10; i++) begin
            scan = (i < 2) ? {8{i[0]}} : 8'($urandom);
            b = 8'($urandom);
            mode = i[0];
            b[0] = mode;
            cmd(8'h35);
            prm(b);
            chk("tearLineMode", {7'd0, mode}, {7'd0, tearLineMode});
            cmd(8'h36);
            prm(scan);
            chk("memoryScanControl", scan & 8'hFC, memoryScanControl);
            chk("tearSyncEnabled", 8'h01, {7'd0, tearSyncEnabled});
            fields = {rowOrderBit, columnOrderBit, rowColumnSwapBit, verticalRefreshDirBit, colorFilterOrderBit,
                      horizontalRefreshDirBit, 2'b00};
            chk("scanFields", scan & 8'hFC, fields);
            chk("topAreaFromBottom", {7'd0, scan[4]}, {7'd0, topAreaFromBottom});
            tearChk(i[1], 1'($urandom), 1'($urandom));
            tearChk(i[1], 1'($urandom), 1'b1);
        end
        cmd(8'h37);
        chk("scrollModeActive", 8'h01, {7'd0, scrollModeActive});
        cmd(8'h13);
        chk("scrollModeActive", 8'h00, {7'd0, scrollModeActive});
        cmd(8'h37);
        cmd(8'h12);
        chk("scrollModeActive", 8'h00, {7'd0, scrollModeActive});
        cmd(8'h34);
        tearOn = 1'b0;
        tearChk(1'b0, 1'b1, 1'b1);
        cmd(8'h35);
        prm(8'h01);
        cmd(8'h01);
        chk("tearSyncEnabled", 8'h00, {7'd0, tearSyncEnabled});
        chk("memoryScanControl", 8'h00, memoryScanControl);
        // hardware reset in mid-run after a fresh setup
        cmd(8'h35);
        prm(8'h01);
        cmd(8'h36);
        prm(8'hA4);
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        chk("tearSyncEnabled", 8'h00, {7'd0, tearSyncEnabled});
        chk("memoryScanControl", 8'h00, memoryScanControl);
        // first write right after release must land
        cmd(8'h36);
        prm(8'h58);
        chk("memoryScanControl", 8'h58, memoryScanControl);
        summarize();
    end
endmodule
